// >>> verilog/gpei_map.svh
// Register indices, field positions, reset values and pin masks of the GPIO block
`ifndef GPEI_MAP_SVH
`define GPEI_MAP_SVH

// ****************************************************************
// Register indices (byte address is four times the index)
// ****************************************************************
`define GPEI_IDX_PC_DATA      10'h000
`define GPEI_IDX_PC_DIR       10'h001
`define GPEI_IDX_PC_OPT       10'h002
`define GPEI_IDX_PB_DATA      10'h004
`define GPEI_IDX_PB_DIR       10'h005
`define GPEI_IDX_PB_OPT       10'h006
`define GPEI_IDX_PA_DATA      10'h008
`define GPEI_IDX_PA_DIR       10'h009
`define GPEI_IDX_PA_OPT       10'h00a
`define GPEI_IDX_MISC1        10'h00c

// ****************************************************************
// Port placement in the flat 24-bit pin vectors
// ****************************************************************
`define GPEI_PA_LSB           0
`define GPEI_PB_LSB           8
`define GPEI_PC_LSB           16
`define GPEI_NPINS            24

// ****************************************************************
// Pin masks
// ****************************************************************
`define GPEI_PIN_IMPL         24'h3fffff
`define GPEI_OPT_IMPL         24'h3fffff
`define GPEI_TOD_PINS         24'h000050
`define GPEI_EI0_FIXED        24'h0000ff
`define GPEI_EI1_FIXED        24'h00ff00
`define GPEI_PC_PINS          24'hff0000

// ****************************************************************
// Miscellaneous register fields and reset values
// ****************************************************************
`define GPEI_IS0_LSB          3
`define GPEI_IS1_LSB          6
`define GPEI_SENS_MASK        8'hd8
`define GPEI_PORT_RST         24'h000000
`define GPEI_MISC_RST         8'h00

`endif

// >>> verilog/gpei_pkg.sv
// Types shared by the GPIO block modules
`default_nettype none
package gpei_pkg;

    // Interrupt sensitivity encodings
    typedef enum logic [1:0] {
        GPEI_SENS_FALL_LOW = 2'b00,
        GPEI_SENS_RISE     = 2'b01,
        GPEI_SENS_FALL     = 2'b10,
        GPEI_SENS_BOTH     = 2'b11
    } gpei_sens_t;

    // Whole state of the top module
    typedef struct packed {
        logic [23:0] data;
        logic [23:0] dir;
        logic [23:0] opt;
        logic [7:0]  misc;
        logic [23:0] sync1;
        logic [23:0] sync2;
        logic        grp;
        logic [31:0] prdata;
        logic        rdy;
        logic        slverr;
    } gpei_top_t;

    // Whole state of one interrupt detector
    typedef struct packed {
        logic prev;
        logic pend;
    } gpei_det_t;

endpackage
`default_nettype wire

// >>> verilog/gpei_irq_if.sv
// Carrier between the port logic and one external interrupt detector
`timescale 1ns/1ps
`default_nettype none
interface gpei_irq_if;
    logic                lvl;
    gpei_pkg::gpei_sens_t sens;
    logic                clr;
    logic                ack;
    logic                req;

    modport det (
        input  lvl,
        input  sens,
        input  clr,
        input  ack,
        output req
    );

    modport ctl (
        output lvl,
        output sens,
        output clr,
        output ack,
        input  req
    );
endinterface
`default_nettype wire

// >>> verilog/gpei_irq_det.sv
// Edge and level detector with request latch for one external interrupt vector
`timescale 1ns/1ps
`default_nettype none
module gpei_irq_det (
    input  wire logic clk_i,
    input  wire logic rst_b_i,
    gpei_irq_if.det   irq
);

    gpei_pkg::gpei_det_t s_r;
    gpei_pkg::gpei_det_t s_nxt;
    logic                fall;
    logic                rise;
    logic                hit;

    // ****************************************************************
    // Event detection
    // ****************************************************************
    always_comb begin
        fall = s_r.prev & ~irq.lvl;
        rise = ~s_r.prev & irq.lvl;
        case (irq.sens)
            gpei_pkg::GPEI_SENS_FALL_LOW: hit = fall;
            gpei_pkg::GPEI_SENS_RISE:     hit = rise;
            gpei_pkg::GPEI_SENS_FALL:     hit = fall;
            gpei_pkg::GPEI_SENS_BOTH:     hit = fall | rise;
            default:                      hit = 1'b0;
        endcase
        s_nxt      = s_r;
        s_nxt.prev = irq.lvl;
        // New event beats a fetch or sensitivity clear in the same cycle
        s_nxt.pend = hit | (s_r.pend & ~(irq.clr | irq.ack));
    end

    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r <= '{prev: 1'b1, pend: 1'b0};
        end else begin
            s_r <= s_nxt;
        end
    end

    // Low level keeps the request up in falling-edge-and-low mode
    assign irq.req = s_r.pend |
                     ((irq.sens == gpei_pkg::GPEI_SENS_FALL_LOW) & ~irq.lvl);

endmodule
`default_nettype wire

// >>> verilog/gpei_top.sv
// Three GPIO ports (8, 8 and 6 pins) with APB registers and two external interrupt vectors
`include "gpei_map.svh"
`timescale 1ns/1ps
`default_nettype none
module gpei_top (
    input  wire logic        clk_i,
    input  wire logic        rst_b_i,
    input  wire logic        psel_i,
    input  wire logic        penable_i,
    input  wire logic        pwrite_i,
    input  wire logic [11:0] paddr_i,
    input  wire logic [31:0] pwdata_i,
    input  wire logic [3:0]  pstrb_i,
    output logic      [31:0] prdata_o,
    output logic             pready_o,
    output logic             pslverr_o,
    input  wire logic [23:0] pad_in_i,
    output logic      [23:0] pad_out_o,
    output logic      [23:0] pad_oe_o,
    output logic      [23:0] pad_pullup_o,
    input  wire logic [23:0] af_out_en_i,
    input  wire logic [23:0] af_out_i,
    output logic      [23:0] af_in_o,
    input  wire logic        irq_mask_i,
    input  wire logic        irq_source_group_option_i,
    input  wire logic [1:0]  vector_fetch_i,
    output logic      [1:0]  irq_o,
    input  wire logic        core_sleep_i,
    input  wire logic        core_stop_i,
    output logic             wake_o,
    output logic      [7:0]  misc_control_one_o
);

    // ****************************************************************
    // State and helper nets
    // ****************************************************************
    gpei_pkg::gpei_top_t s_r;
    gpei_pkg::gpei_top_t s_nxt;

    logic [23:0] pin_rd;
    logic [23:0] irq_en;
    logic [23:0] opt_eff;
    logic [23:0] ei0_members;
    logic [23:0] ei1_members;
    logic [1:0]  sens_clr;
    logic [1:0]  det_req;
    logic        acc;
    logic        wr_done;
    logic [9:0]  idx;
    logic [7:0]  wbyte;
    logic [7:0]  misc_w;
    logic [31:0] rdata;
    logic        mapped;

    gpei_irq_if irq_bus [2] ();

    assign acc     = psel_i & penable_i;
    assign wr_done = acc & s_r.rdy & pwrite_i & pstrb_i[0];
    assign idx     = paddr_i[11:2];
    assign wbyte   = pwdata_i[7:0];

    // ****************************************************************
    // Per-pin configuration decode
    // ****************************************************************
    assign opt_eff = s_r.opt & `GPEI_OPT_IMPL;

    localparam logic [23:0] PIN_IMPL = `GPEI_PIN_IMPL;
    localparam logic [23:0] TOD_PINS = `GPEI_TOD_PINS;

    genvar gi;
    generate
        for (gi = 0; gi < `GPEI_NPINS; gi = gi + 1) begin : g_pin
            logic impl;
            logic tod;
            logic dir;
            logic opt;
            logic afo;
            logic push;

            assign impl = PIN_IMPL[gi];
            assign tod  = TOD_PINS[gi];
            assign dir  = s_r.dir[gi];
            assign opt  = opt_eff[gi];
            assign afo  = af_out_en_i[gi] & impl;
            // True open drain pins never drive high unless the alternate output owns them
            assign push = dir & opt & ~tod;

            // Alternate output takes priority over port programming
            always_comb begin
                if (afo) begin
                    pad_out_o[gi] = af_out_i[gi];
                    pad_oe_o[gi]  = 1'b1;
                end else begin
                    pad_out_o[gi] = s_r.data[gi];
                    // Open drain releases the pin on a one
                    pad_oe_o[gi]  = impl & dir & (push | ~s_r.data[gi]);
                end
            end

            // Pull-up only on standard pins in pull-up input mode
            assign pad_pullup_o[gi] = impl & ~afo & ~dir & opt & ~tod;

            // Interrupt input: direction zero, option one
            assign irq_en[gi] = impl & ~afo & ~dir & opt;

            // Data register read-back
            always_comb begin
                if (!impl) begin
                    pin_rd[gi] = 1'b0;
                end else if (!dir && afo) begin
                    pin_rd[gi] = af_out_i[gi];
                end else if (dir) begin
                    pin_rd[gi] = s_r.data[gi];
                end else begin
                    pin_rd[gi] = s_r.sync2[gi];
                end
            end

            // Alternate input sees the latch when the pin is an output
            assign af_in_o[gi] = dir ? s_r.data[gi] : s_r.sync2[gi];
        end
    endgenerate

    // ****************************************************************
    // Interrupt source grouping and combination
    // ****************************************************************
    always_comb begin
        // Port C joins vector one unless the strap moves it to vector zero
        if (s_r.grp) begin
            ei0_members = `GPEI_EI0_FIXED | `GPEI_PC_PINS;
            ei1_members = `GPEI_EI1_FIXED;
        end else begin
            ei0_members = `GPEI_EI0_FIXED;
            ei1_members = `GPEI_EI1_FIXED | `GPEI_PC_PINS;
        end
    end

    // Shared vector: one enabled pin held low masks the others
    assign irq_bus[0].lvl = &(~(irq_en & ei0_members) | s_r.sync2);
    assign irq_bus[1].lvl = &(~(irq_en & ei1_members) | s_r.sync2);
    assign irq_bus[0].sens = gpei_pkg::gpei_sens_t'(s_r.misc[`GPEI_IS0_LSB +: 2]);
    assign irq_bus[1].sens = gpei_pkg::gpei_sens_t'(s_r.misc[`GPEI_IS1_LSB +: 2]);

    genvar gv;
    generate
        for (gv = 0; gv < 2; gv = gv + 1) begin : g_vec
            assign irq_bus[gv].clr = sens_clr[gv];
            assign irq_bus[gv].ack = vector_fetch_i[gv];
            assign det_req[gv]     = irq_bus[gv].req;

            gpei_irq_det u_det (
                .clk_i   (clk_i),
                .rst_b_i (rst_b_i),
                .irq     (irq_bus[gv])
            );
        end
    endgenerate

    // Requests reach the core only while it is unmasked
    assign irq_o = det_req & {2{~irq_mask_i}};

    // Pin configuration ignores sleep and stop; a request ends either
    assign wake_o = (core_sleep_i | core_stop_i) & (|det_req);

    // ****************************************************************
    // Sensitivity write protection and pending clear
    // ****************************************************************
    always_comb begin
        if (irq_mask_i) begin
            misc_w = wbyte;
        end else begin
            // Sensitivity fields hold while the core is unmasked
            misc_w = (wbyte & ~`GPEI_SENS_MASK) | (s_r.misc & `GPEI_SENS_MASK);
        end
        sens_clr = 2'b00;
        if (wr_done && idx == `GPEI_IDX_MISC1) begin
            sens_clr[0] = misc_w[`GPEI_IS0_LSB +: 2] != s_r.misc[`GPEI_IS0_LSB +: 2];
            sens_clr[1] = misc_w[`GPEI_IS1_LSB +: 2] != s_r.misc[`GPEI_IS1_LSB +: 2];
        end
    end

    // ****************************************************************
    // Register read decode
    // ****************************************************************
    always_comb begin
        rdata  = 32'h0000_0000;
        mapped = 1'b1;
        case (idx)
            `GPEI_IDX_PC_DATA: rdata[7:0] = pin_rd[`GPEI_PC_LSB +: 8];
            `GPEI_IDX_PC_DIR:  rdata[7:0] = s_r.dir[`GPEI_PC_LSB +: 8];
            `GPEI_IDX_PC_OPT:  rdata[7:0] = s_r.opt[`GPEI_PC_LSB +: 8];
            `GPEI_IDX_PB_DATA: rdata[7:0] = pin_rd[`GPEI_PB_LSB +: 8];
            `GPEI_IDX_PB_DIR:  rdata[7:0] = s_r.dir[`GPEI_PB_LSB +: 8];
            `GPEI_IDX_PB_OPT:  rdata[7:0] = s_r.opt[`GPEI_PB_LSB +: 8];
            `GPEI_IDX_PA_DATA: rdata[7:0] = pin_rd[`GPEI_PA_LSB +: 8];
            `GPEI_IDX_PA_DIR:  rdata[7:0] = s_r.dir[`GPEI_PA_LSB +: 8];
            `GPEI_IDX_PA_OPT:  rdata[7:0] = s_r.opt[`GPEI_PA_LSB +: 8];
            `GPEI_IDX_MISC1:   rdata[7:0] = s_r.misc;
            default:           mapped = 1'b0;
        endcase
    end

    // ****************************************************************
    // Next state
    // ****************************************************************
    always_comb begin
        s_nxt       = s_r;
        s_nxt.sync1 = pad_in_i;
        s_nxt.sync2 = s_r.sync1;
        s_nxt.grp   = irq_source_group_option_i;

        // One wait state: answer on the second access cycle
        s_nxt.rdy = acc & ~s_r.rdy;
        if (acc && !s_r.rdy) begin
            s_nxt.prdata = pwrite_i ? 32'h0000_0000 : rdata;
            s_nxt.slverr = ~mapped;
        end else begin
            s_nxt.slverr = 1'b0;
        end

        if (wr_done) begin
            case (idx)
                `GPEI_IDX_PC_DATA: s_nxt.data[`GPEI_PC_LSB +: 8] = wbyte;
                `GPEI_IDX_PC_DIR:  s_nxt.dir[`GPEI_PC_LSB +: 8]  = wbyte;
                `GPEI_IDX_PC_OPT:  s_nxt.opt[`GPEI_PC_LSB +: 8]  = wbyte;
                `GPEI_IDX_PB_DATA: s_nxt.data[`GPEI_PB_LSB +: 8] = wbyte;
                `GPEI_IDX_PB_DIR:  s_nxt.dir[`GPEI_PB_LSB +: 8]  = wbyte;
                `GPEI_IDX_PB_OPT:  s_nxt.opt[`GPEI_PB_LSB +: 8]  = wbyte;
                `GPEI_IDX_PA_DATA: s_nxt.data[`GPEI_PA_LSB +: 8] = wbyte;
                `GPEI_IDX_PA_DIR:  s_nxt.dir[`GPEI_PA_LSB +: 8]  = wbyte;
                `GPEI_IDX_PA_OPT:  s_nxt.opt[`GPEI_PA_LSB +: 8]  = wbyte;
                `GPEI_IDX_MISC1:   s_nxt.misc = misc_w;
                default:           s_nxt.misc = s_r.misc;
            endcase
        end
    end

    // ****************************************************************
    // State register
    // ****************************************************************
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            s_r.data   <= `GPEI_PORT_RST;
            s_r.dir    <= `GPEI_PORT_RST;
            s_r.opt    <= `GPEI_PORT_RST;
            s_r.misc   <= `GPEI_MISC_RST;
            s_r.sync1  <= 24'h000000;
            s_r.sync2  <= 24'h000000;
            s_r.grp    <= 1'b0;
            s_r.prdata <= 32'h0000_0000;
            s_r.rdy    <= 1'b0;
            s_r.slverr <= 1'b0;
        end else begin
            s_r <= s_nxt;
        end
    end

    // ****************************************************************
    // Outputs
    // ****************************************************************
    assign prdata_o           = s_r.prdata;
    assign pready_o           = s_r.rdy;
    assign pslverr_o          = s_r.slverr;
    assign misc_control_one_o = s_r.misc;

endmodule
`default_nettype wire

// >>> verif/gpei_checker.sv
// Port assertions for the GPIO block
`include "gpei_map.svh"
`timescale 1ns/1ps
`default_nettype none
module gpei_checker (
    input wire logic        clk_i,
    input wire logic        rst_b_i,
    input wire logic        psel_i,
    input wire logic        penable_i,
    input wire logic        pwrite_i,
    input wire logic [11:0] paddr_i,
    input wire logic [31:0] prdata_o,
    input wire logic        pready_o,
    input wire logic        pslverr_o,
    input wire logic [23:0] pad_out_o,
    input wire logic [23:0] pad_oe_o,
    input wire logic [23:0] pad_pullup_o,
    input wire logic [23:0] af_out_en_i,
    input wire logic [23:0] af_out_i,
    input wire logic        irq_mask_i,
    input wire logic [1:0]  irq_o,
    input wire logic        core_sleep_i,
    input wire logic        core_stop_i,
    input wire logic        wake_o,
    input wire logic [7:0]  misc_control_one_o
);
    logic        wr_misc;
    logic [23:0] af_bits;
    assign wr_misc = psel_i && penable_i && pready_o && pwrite_i &&
                     paddr_i[11:2] == `GPEI_IDX_MISC1;
    assign af_bits = af_out_en_i & `GPEI_PIN_IMPL;
    default clocking @(posedge clk_i); endclocking
    default disable iff (!rst_b_i);
    sequence s_setup;
        psel_i && !penable_i;
    endsequence
    sequence s_answer;
        !pready_o ##1 pready_o;
    endsequence
    property p_wait;
        s_setup |=> s_answer;
    endproperty
    a_wait: assert property (p_wait) else $error("Answer not in second access cycle");
    property p_pulse;
        pready_o |=> !pready_o;
    endproperty
    a_pulse: assert property (p_pulse) else $error("Ready held too long");
    property p_err;
        pslverr_o |-> pready_o && prdata_o == 32'h0;
    endproperty
    a_err: assert property (p_err) else $error("Error answer malformed");
    property p_af;
        (pad_oe_o & af_bits) == af_bits && (pad_out_o & af_bits) == (af_out_i & af_bits);
    endproperty
    a_af: assert property (p_af) else $error("Alternate output lost priority");
    property p_absent;
        ((pad_oe_o | pad_pullup_o) & ~`GPEI_PIN_IMPL) == 24'h0;
    endproperty
    a_absent: assert property (p_absent) else $error("Absent pin active");
    property p_tod;
        (pad_pullup_o & `GPEI_TOD_PINS) == 24'h0 &&
        (pad_oe_o & pad_out_o & `GPEI_TOD_PINS & ~af_bits) == 24'h0;
    endproperty
    a_tod: assert property (p_tod) else $error("Open drain pin drives high");
    property p_pull;
        (pad_pullup_o & pad_oe_o & ~af_bits) == 24'h0;
    endproperty
    a_pull: assert property (p_pull) else $error("Pull-up on driven pin");
    property p_mask;
        irq_mask_i |-> irq_o == 2'b00;
    endproperty
    a_mask: assert property (p_mask) else $error("Request while masked");
    property p_wake;
        (core_sleep_i || core_stop_i) && !irq_mask_i |-> wake_o == |irq_o;
    endproperty
    a_wake: assert property (p_wake) else $error("Wake does not follow request");
    property p_awake;
        !(core_sleep_i || core_stop_i) |-> !wake_o;
    endproperty
    a_awake: assert property (p_awake) else $error("Wake while running");
    property p_lock;
        $changed(misc_control_one_o & `GPEI_SENS_MASK) |->
            ($past(wr_misc) && $past(irq_mask_i)) || ($past(wr_misc, 2) && $past(irq_mask_i, 2));
    endproperty
    a_lock: assert property (p_lock) else $error("Sensitivity changed while unmasked");
    property p_src;
        $changed(misc_control_one_o) |-> $past(wr_misc) || $past(wr_misc, 2);
    endproperty
    a_src: assert property (p_src) else $error("Control register changed without write");
endmodule
bind gpei_top gpei_checker gpei_checker_i (.clk_i, .rst_b_i, .psel_i, .penable_i, .pwrite_i,
    .paddr_i, .prdata_o, .pready_o, .pslverr_o, .pad_out_o, .pad_oe_o, .pad_pullup_o,
    .af_out_en_i, .af_out_i, .irq_mask_i, .irq_o, .core_sleep_i, .core_stop_i, .wake_o,
    .misc_control_one_o);
`default_nettype wire

// >>> verif/gpei_pins.sv
// Model of the circuitry on the port pins
`timescale 1ns/1ps
`default_nettype none
module gpei_pins (
    input  wire logic        clk_i,
    input  wire logic [23:0] pad_out_i,
    input  wire logic [23:0] pad_oe_i,
    input  wire logic [23:0] pad_pullup_i,
    input  wire logic [23:0] ext_val_i,
    input  wire logic [23:0] ext_en_i,
    output logic      [23:0] pad_o
);
    // Undriven pins without pull-up wander every cycle
    logic wander_r = 1'b0;
    always @(posedge clk_i) begin
        wander_r <= ~wander_r;
    end
    assign pad_o = (pad_oe_i & pad_out_i) | (~pad_oe_i & ((ext_en_i & ext_val_i) |
                   (~ext_en_i & (pad_pullup_i | {24{wander_r}}))));
endmodule
`default_nettype wire

// >>> verif/gpei_top_tb.sv
// Self-checking bench of the GPIO block against a register and pin model
`include "gpei_map.svh"
`timescale 1ns/1ps
`default_nettype none
module gpei_top_tb;
    logic        clk_i = 1'b0;
    logic        rst_b_i = 1'b0;
    logic        psel = 1'b0;
    logic        pen = 1'b0;
    logic        pwr = 1'b0;
    logic [11:0] paddr = 12'h000;
    logic [31:0] pwdata = 32'h0;
    logic [3:0]  pstrb = 4'hf;
    logic [31:0] prdata;
    logic        pready;
    logic        perr;
    logic [23:0] pad, pout, poe, ppu, af_in;
    logic [23:0] af_en = 24'h0;
    logic [23:0] af_out = 24'h0;
    logic [23:0] ext = 24'h0;
    logic        mask = 1'b1;
    logic        grp = 1'b0;
    logic [1:0]  fetch = 2'b00;
    logic [1:0]  irq;
    logic        sleep = 1'b0;
    logic        stop = 1'b0;
    logic        wake;
    logic [7:0]  misc;
    logic [7:0]  mreg [0:15] = '{default: 8'h00};
    logic [3:0]  tbl [0:10] = '{4'h0, 4'h1, 4'h2, 4'h4, 4'h5, 4'h6, 4'h8, 4'h9, 4'ha, 4'h3, 4'hf};
    int          n_mismatch = 0;
    int          comparisons = 0;
    int          cyc = 0;
    int          seed = 10;
    int          m;
    gpei_top gpei_top_i (
        .clk_i(clk_i), .rst_b_i(rst_b_i), .psel_i(psel), .penable_i(pen), .pwrite_i(pwr),
        .paddr_i(paddr), .pwdata_i(pwdata), .pstrb_i(pstrb), .prdata_o(prdata),
        .pready_o(pready), .pslverr_o(perr), .pad_in_i(pad), .pad_out_o(pout),
        .pad_oe_o(poe), .pad_pullup_o(ppu), .af_out_en_i(af_en), .af_out_i(af_out),
        .af_in_o(af_in), .irq_mask_i(mask), .irq_source_group_option_i(grp),
        .vector_fetch_i(fetch), .irq_o(irq), .core_sleep_i(sleep), .core_stop_i(stop),
        .wake_o(wake), .misc_control_one_o(misc)
    );
    gpei_pins gpei_pins_i (
        .clk_i(clk_i), .pad_out_i(pout), .pad_oe_i(poe), .pad_pullup_i(ppu),
        .ext_val_i(ext), .ext_en_i(24'hffffff), .pad_o(pad)
    );
    always #2.5 clk_i = ~clk_i;
    always @(posedge clk_i) begin
        cyc <= cyc + 1;
        if (cyc == 20000) begin
            n_mismatch++;
            finish_test();
        end
    end
    // ****************************************************************
    // Model and checking tasks
    // ****************************************************************
    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        comparisons++;
        if (got !== exp) begin
            n_mismatch++;
            $display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
        end
    endtask
    task automatic finish_test();
        $display("Comparisons %0d mismatches %0d", comparisons, n_mismatch);
        if (n_mismatch == 0 && comparisons > 0) begin
            $display("NO MISMATCHES");
        end else begin
            $display("MISMATCHES SEEN");
        end
        $finish;
    endtask
    function automatic logic [23:0] v24(input int b);
        return {mreg[b], mreg[b + 4], mreg[b + 8]};
    endfunction
    function automatic logic mapped(input logic [3:0] i);
        return !(i == 4'h3 || i == 4'h7 || i == 4'hb || i > 4'hc);
    endfunction
    function automatic logic [7:0] mexp(input logic [3:0] i);
        logic [23:0] d;
        d = `GPEI_PIN_IMPL & ((v24(1) & v24(0)) | (~v24(1) & ((af_en & af_out) | (~af_en & ext))));
        if (i == 4'h0 || i == 4'h4 || i == 4'h8) begin
            return d[16 - 2 * int'(i) +: 8];
        end
        return mreg[i];
    endfunction
    task automatic acc(input logic w, input logic [3:0] i, input logic [7:0] d);
        logic [7:0] e;
        int         k;
        e = mexp(i);
        @(posedge clk_i);
        psel <= 1'b1;
        pwr <= w;
        paddr <= {6'h00, i, 2'b00};
        pwdata <= {24'h0, d};
        @(posedge clk_i);
        pen <= 1'b1;
        k = 0;
        do begin
            @(posedge clk_i);
            k++;
        end while (pready !== 1'b1 && k < 8);
        chk({31'h0, pready}, 32'h1);
        chk({31'h0, perr}, {31'h0, !mapped(i)});
        if (!w) chk(prdata, {24'h0, e});
        psel <= 1'b0;
        pen <= 1'b0;
        if (w && mapped(i) && pstrb[0]) begin
            if (i == 4'hc && !mask) mreg[i] = (mreg[i] & 8'hd8) | (d & 8'h27);
            else mreg[i] = d;
        end
    endtask
    task automatic pins();
        logic [23:0] dir_v, dat_v, opt_v;
        repeat (3) @(posedge clk_i);
        #1;
        dir_v = v24(1);
        dat_v = v24(0);
        opt_v = v24(2);
        chk({8'h0, poe}, {8'h0, `GPEI_PIN_IMPL & (af_en | (dir_v & ((opt_v & ~`GPEI_TOD_PINS) |
            ~dat_v)))});
        chk({8'h0, ppu & ~af_en}, {8'h0, `GPEI_PIN_IMPL & ~dir_v & opt_v & ~`GPEI_TOD_PINS &
            ~af_en});
        chk({8'h0, pout & `GPEI_PIN_IMPL}, {8'h0, `GPEI_PIN_IMPL & ((af_en & af_out) |
            (~af_en & dat_v))});
        chk({8'h0, af_in & `GPEI_PIN_IMPL}, {8'h0, `GPEI_PIN_IMPL & ((dir_v & dat_v) | (~dir_v &
            ((af_en & af_out) | (~af_en & ext))))});
    endtask
    task automatic fetch1(input int v);
        @(posedge clk_i);
        fetch[v] <= 1'b1;
        @(posedge clk_i);
        fetch[v] <= 1'b0;
    endtask
    task automatic irqchk(input logic [23:0] x, input logic [1:0] e);
        @(posedge clk_i);
        ext <= x;
        repeat (6) @(posedge clk_i);
        #1;
        chk({30'h0, irq}, {30'h0, e});
        chk({31'h0, wake}, {31'h0, (sleep | stop) & |e});
    endtask
    // ****************************************************************
    // Main sequence
    // ****************************************************************
    initial begin
        logic [7:0] d;
        logic [3:0] i;
        repeat (12) @(posedge clk_i);
        rst_b_i <= 1'b1;
        for (int k = 0; k < 11; k++) acc(1'b0, tbl[k], 8'h00);
        acc(1'b0, 4'hc, 8'h00);
        acc(1'b1, 4'hf, 8'h5a);
        pins();
        for (int n = 0; n < 60; n++) begin
            i = tbl[$unsigned($random(seed)) % 11];
            d = 8'($random(seed));
            if (i < 4'h3) d = d & 8'h3f;
            pstrb <= (n % 7 == 6) ? 4'he : 4'hf;
            acc(1'b1, i, d);
            ext <= 24'($random(seed));
            af_en <= (n % 3 == 0) ? 24'($random(seed)) : 24'h0;
            af_out <= 24'($random(seed));
            pins();
            acc(1'b0, i, 8'h00);
            acc(1'b0, tbl[n % 11], 8'h00);
        end
        pstrb <= 4'hf;
        af_en <= 24'h0;
        ext <= 24'h000001;
        acc(1'b1, 4'h6, 8'h00);
        acc(1'b1, 4'h2, 8'h00);
        acc(1'b1, 4'ha, 8'h01);
        acc(1'b1, 4'h9, 8'h00);
        acc(1'b1, 4'h1, 8'h00);
        fetch1(0);
        fetch1(1);
        for (m = 0; m < 4; m++) begin
            mask <= 1'b1;
            acc(1'b1, 4'hc, 8'(m * 72));
            sleep <= m[0];
            stop <= m[1];
            mask <= 1'b0;
            irqchk(24'h1, 2'b00);
            irqchk(24'h0, {1'b0, m != 1});
            fetch1(0);
            irqchk(24'h0, {1'b0, m == 0});
            irqchk(24'h1, {1'b0, m[0]});
            mask <= 1'b1;
            @(posedge clk_i);
            #1;
            chk({30'h0, irq}, 32'h0);
        end
        mask <= 1'b0;
        acc(1'b1, 4'hc, 8'h00);
        acc(1'b0, 4'hc, 8'h00);
        chk({24'h0, misc}, {24'h0, mreg[12]});
        irqchk(24'h000001, 2'b01);
        fetch1(0);
        irqchk(24'h010001, 2'b00);
        acc(1'b1, 4'ha, 8'h00);
        acc(1'b1, 4'h2, 8'h01);
        irqchk(24'h000001, 2'b10);
        fetch1(1);
        irqchk(24'h010001, 2'b10);
        fetch1(1);
        grp <= 1'b1;
        irqchk(24'h010001, 2'b00);
        irqchk(24'h000001, 2'b01);
        acc(1'b1, 4'ha, 8'h02);
        fetch1(0);
        irqchk(24'h010001, 2'b00);
        finish_test();
    end
endmodule
`default_nettype wire
